// [src/pxo_output_port.sv]
`timescale 1ns/1ns
`default_nettype none

module pxo_output_port #(
  parameter int unsigned CHAN_W   = pxo_pkg::CHAN_W,
  parameter int unsigned GAIN_W   = 8,
  parameter int unsigned OFFSET_W = 8
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic                       reg_wr_en,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wr_data,
  input  wire logic                       adc_valid,
  output var  logic                       adc_ready,
  input  wire logic [3*CHAN_W-1:0]        adc_set1_pixel,
  input  wire logic [3*CHAN_W-1:0]        adc_set2_pixel,
  input  wire logic                       blank_active,
  input  wire logic signed [OFFSET_W-1:0] red_offset_value,
  input  wire logic signed [OFFSET_W-1:0] green_offset_value,
  input  wire logic signed [OFFSET_W-1:0] blue_offset_value,
  input  wire logic [GAIN_W-1:0]          red_gain_level,
  input  wire logic [GAIN_W-1:0]          green_gain_level,
  input  wire logic [GAIN_W-1:0]          blue_gain_level,
  input  wire logic [2:0]                 range_flag_in,
  input  wire logic                       out_ready,
  output var  logic                       input_set_select,
  output var  logic                       track_hold_disable,
  output var  logic [GAIN_W-1:0]          gain_monitor_pin,
  output var  logic [3*CHAN_W-1:0]        port_a_data,
  output var  logic                       port_a_strobe,
  output var  logic                       port_a_oe,
  output var  logic [3*CHAN_W-1:0]        port_b_data,
  output var  logic                       port_b_strobe,
  output var  logic                       port_b_oe,
  output var  logic [2:0]                 range_flag_out,
  output var  logic                       range_flag_oe
);
  localparam int unsigned PIX_W = 3 * CHAN_W;

  logic [pxo_pkg::REG_W-1:0] pixel_format_control;
  logic [pxo_pkg::TRI_W-1:0] port_tristate_control;
  pxo_pkg::pxo_phase_type    phase;
  logic [PIX_W-1:0]          first_pixel;
  logic                      b_pending;
  logic [PIX_W-1:0]          b_pending_pixel;

  pxo_pix_if #(.WIDTH(PIX_W)) buf_fill ();
  pxo_pix_if #(.WIDTH(PIX_W)) buf_drain ();

  // clamp a signed offset to a channel code, negative gives zero
  function automatic logic [CHAN_W-1:0] blank_level(input logic signed [OFFSET_W-1:0] v);
    logic [OFFSET_W-1:0] mag;
    mag = v;
    if (v < 0) begin
      return '0;
    end
    return CHAN_W'(mag);
  endfunction

  function automatic logic [CHAN_W-1:0] chan(input logic [PIX_W-1:0] p, input int unsigned lsb);
    return p[lsb +: CHAN_W];
  endfunction

  // register write decode
  wire fmt_wr = reg_wr_en & (reg_addr == pxo_pkg::PIXEL_FORMAT_CONTROL_ADDR);
  wire tri_wr = reg_wr_en & (reg_addr == pxo_pkg::PORT_TRISTATE_CONTROL_ADDR);

  // control fields
  wire       sel_set2      = pixel_format_control[pxo_pkg::FMT_INPUT_SET_BIT];
  wire [1:0] gain_sel      = pixel_format_control[pxo_pkg::FMT_GAIN_SEL_HI:
                                                  pxo_pkg::FMT_GAIN_SEL_LO];
  wire       blank_inhibit = pixel_format_control[pxo_pkg::FMT_BLANK_INHIBIT_BIT];
  wire       dual_port     = pixel_format_control[pxo_pkg::FMT_DUAL_PORT_BIT];
  wire       odd_on_a      = pixel_format_control[pxo_pkg::FMT_PARITY_BIT];
  wire       stagger       = pixel_format_control[pxo_pkg::FMT_STAGGER_BIT];
  wire       b_float       = port_tristate_control[pxo_pkg::TRI_PORT_B_FLOAT_BIT];
  wire       a_float       = port_tristate_control[pxo_pkg::TRI_PORT_A_FLOAT_BIT];
  wire       range_float   = port_tristate_control[pxo_pkg::TRI_RANGE_FLOAT_BIT];
  wire       test_mode     = port_tristate_control[pxo_pkg::TRI_TEST_ENABLE_BIT];
  wire       test_level    = port_tristate_control[pxo_pkg::TRI_TEST_LEVEL_BIT];
  wire       track_hold    = pixel_format_control[pxo_pkg::FMT_TRACK_HOLD_BIT];

  // input set choice and blanking substitution
  wire [PIX_W-1:0] raw_pixel   = sel_set2 ? adc_set2_pixel : adc_set1_pixel;
  wire             substitute  = blank_active & ~blank_inhibit;
  wire [CHAN_W-1:0] red_in     = substitute ? blank_level(red_offset_value)
                                            : chan(raw_pixel, pxo_pkg::RED_LSB);
  wire [CHAN_W-1:0] green_in   = substitute ? blank_level(green_offset_value)
                                            : chan(raw_pixel, pxo_pkg::GREEN_LSB);
  wire [CHAN_W-1:0] blue_in    = substitute ? blank_level(blue_offset_value)
                                            : chan(raw_pixel, pxo_pkg::BLUE_LSB);
  wire [PIX_W-1:0]  in_pixel   = {red_in, green_in, blue_in};

  assign buf_fill.valid = adc_valid;
  assign buf_fill.data  = in_pixel;
  assign adc_ready      = buf_fill.ready;

  // two entries ride out a receiver stall with no word lost
  pxo_pixel_buffer #(
    .WIDTH (PIX_W),
    .DEPTH (pxo_pkg::BUF_DEPTH)
  ) u_buffer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .fill     (buf_fill),
    .drain    (buf_drain)
  );

  // downstream stall holds pixels in the buffer
  assign buf_drain.ready = out_ready;
  wire             take      = buf_drain.valid & out_ready;
  wire [PIX_W-1:0] pix       = buf_drain.data;
  wire             pair_done = take & dual_port & (phase == pxo_pkg::PXO_PH_SECOND);
  // a format write or single port mode restarts pairing on an even pixel
  wire             restart_pair = fmt_wr | ~dual_port;
  wire             keep_first   = take & (phase == pxo_pkg::PXO_PH_FIRST);

  // even pixel is the first of a pair, odd the second
  wire [PIX_W-1:0] pair_a = odd_on_a ? pix : first_pixel;
  wire [PIX_W-1:0] pair_b = odd_on_a ? first_pixel : pix;

  // phase sequencing
  pxo_pkg::pxo_phase_type next_phase;
  always_comb begin
    next_phase = phase;
    if (restart_pair) begin
      next_phase = pxo_pkg::PXO_PH_FIRST;
    end else if (take) begin
      unique case (phase)
        pxo_pkg::PXO_PH_FIRST:  next_phase = pxo_pkg::PXO_PH_SECOND;
        pxo_pkg::PXO_PH_SECOND: next_phase = pxo_pkg::PXO_PH_FIRST;
      endcase
    end
  end

  // next values of port A
  wire             a_load     = dual_port ? pair_done : take;
  wire [PIX_W-1:0] a_pixel    = dual_port ? pair_a : pix;
  // next values of port B, immediate or one clock later
  wire             b_now      = pair_done & ~stagger;
  wire             b_defer    = pair_done & stagger;
  wire             b_load     = b_now | b_pending;
  wire [PIX_W-1:0] b_pixel    = b_pending ? b_pending_pixel : pair_b;
  wire [PIX_W-1:0] test_pixel = {PIX_W{test_level}};
  wire [pxo_pkg::RANGE_W-1:0] next_range = test_mode ? {pxo_pkg::RANGE_W{test_level}}
                                                     : range_flag_in;

  // gain monitor mux
  // unused code drives zero rather than a stale level
  logic [GAIN_W-1:0] next_gain_monitor;
  always_comb begin
    unique case (gain_sel)
      pxo_pkg::GAIN_SEL_RED:   next_gain_monitor = red_gain_level;
      pxo_pkg::GAIN_SEL_GREEN: next_gain_monitor = green_gain_level;
      pxo_pkg::GAIN_SEL_BLUE:  next_gain_monitor = blue_gain_level;
      pxo_pkg::GAIN_SEL_NONE:  next_gain_monitor = '0;
    endcase
  end

  // control registers, write only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pixel_format_control <= pxo_pkg::FMT_RESET;
    end else if (fmt_wr) begin
      pixel_format_control <= reg_wr_data;
    end
  end

  // upper three bits of the tristate write are dropped
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_tristate_control <= pxo_pkg::TRI_RESET;
    end else if (tri_wr) begin
      port_tristate_control <= reg_wr_data[pxo_pkg::TRI_W-1:0];
    end
  end

  // pairing state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= pxo_pkg::PXO_PH_FIRST;
    end else begin
      phase <= next_phase;
    end
  end

  // even pixel waits here until its partner drains
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_pixel <= '0;
    end else if (keep_first) begin
      first_pixel <= pix;
    end
  end

  // interleaved port B value held back one clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      b_pending       <= 1'b0;
      b_pending_pixel <= '0;
    end else begin
      b_pending <= b_defer;
      if (b_defer) begin
        b_pending_pixel <= pair_b;
      end
    end
  end

  // port A, forced to the test level in buffer test mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_data   <= '0;
      port_a_strobe <= 1'b0;
    end else if (test_mode) begin
      port_a_data   <= test_pixel;
      port_a_strobe <= 1'b0;
    end else begin
      port_a_strobe <= a_load;
      if (a_load) begin
        port_a_data <= a_pixel;
      end
    end
  end

  // port B, same forcing as port A
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_b_data   <= '0;
      port_b_strobe <= 1'b0;
    end else if (test_mode) begin
      port_b_data   <= test_pixel;
      port_b_strobe <= 1'b0;
    end else begin
      port_b_strobe <= b_load;
      if (b_load) begin
        port_b_data <= b_pixel;
      end
    end
  end

  // drive enables follow the float bits, test mode included
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_oe     <= 1'b0;
      port_b_oe     <= 1'b0;
      range_flag_oe <= 1'b0;
    end else begin
      port_a_oe     <= ~a_float;
      port_b_oe     <= ~b_float;
      range_flag_oe <= ~range_float;
    end
  end

  // range flags one clock late, or forced in test mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      range_flag_out <= '0;
    end else begin
      range_flag_out <= next_range;
    end
  end

  // gain monitor pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_monitor_pin <= '0;
    end else begin
      gain_monitor_pin <= next_gain_monitor;
    end
  end

  // front-end controls for the converter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_set_select   <= 1'b0;
      track_hold_disable <= 1'b0;
    end else begin
      input_set_select   <= sel_set2;
      track_hold_disable <= track_hold;
    end
  end
endmodule

`default_nettype wire

// [src/pxo_pix_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface pxo_pix_if #(
  parameter int unsigned WIDTH = 24
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// [src/pxo_pixel_buffer.sv]
`timescale 1ns/1ns
`default_nettype none

module pxo_pixel_buffer #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  pxo_pix_if.snk    fill,
  pxo_pix_if.src    drain
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL  = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
  localparam logic [PTR_W-1:0] PTR_LAST  = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ONE   = PTR_W'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             room;
  logic             empty;

  wire push = fill.valid & room;
  wire pop  = drain.ready & ~empty;
  wire [CNT_W-1:0] next_count = push & ~pop ? count + CNT_ONE :
                                pop & ~push ? count - CNT_ONE : count;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? '0 : p + PTR_ONE;
  endfunction

  // registered flags keep ready and valid glitch free at the ports
  assign fill.ready  = room;
  assign drain.valid = ~empty;
  assign drain.data  = mem[rd_ptr];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      room   <= 1'b1;
      empty  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= next_count;
      room  <= next_count != CNT_FULL;
      empty <= next_count == '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end
endmodule

`default_nettype wire

// [src/pxo_pkg.sv]
package pxo_pkg;

  // register addresses on the control write port
  localparam logic [7:0] PIXEL_FORMAT_CONTROL_ADDR  = 8'h17;
  localparam logic [7:0] PORT_TRISTATE_CONTROL_ADDR = 8'h18;

  localparam int unsigned REG_W   = 8;
  localparam int unsigned CHAN_W  = 8;
  localparam int unsigned PIXEL_W = 3 * CHAN_W;

  // pixel_format_control fields
  localparam int unsigned FMT_INPUT_SET_BIT     = 7;
  localparam int unsigned FMT_TRACK_HOLD_BIT    = 6;
  localparam int unsigned FMT_GAIN_SEL_HI       = 5;
  localparam int unsigned FMT_GAIN_SEL_LO       = 4;
  localparam int unsigned FMT_BLANK_INHIBIT_BIT = 3;
  localparam int unsigned FMT_DUAL_PORT_BIT     = 2;
  localparam int unsigned FMT_PARITY_BIT        = 1;
  localparam int unsigned FMT_STAGGER_BIT       = 0;
  localparam logic [7:0]  FMT_RESET             = 8'h00;

  // port_tristate_control fields, bits 7..5 unused and not stored
  localparam int unsigned TRI_W                = 5;
  localparam int unsigned TRI_PORT_B_FLOAT_BIT = 4;
  localparam int unsigned TRI_PORT_A_FLOAT_BIT = 3;
  localparam int unsigned TRI_RANGE_FLOAT_BIT  = 2;
  localparam int unsigned TRI_TEST_ENABLE_BIT  = 1;
  localparam int unsigned TRI_TEST_LEVEL_BIT   = 0;
  localparam logic [4:0]  TRI_RESET            = 5'h1C;

  // gain monitor selection codes
  localparam logic [1:0] GAIN_SEL_RED   = 2'h0;
  localparam logic [1:0] GAIN_SEL_GREEN = 2'h1;
  localparam logic [1:0] GAIN_SEL_BLUE  = 2'h2;
  localparam logic [1:0] GAIN_SEL_NONE  = 2'h3;

  // channel order inside a packed pixel
  localparam int unsigned RED_LSB   = 2 * CHAN_W;
  localparam int unsigned GREEN_LSB = CHAN_W;
  localparam int unsigned BLUE_LSB  = 0;

  localparam int unsigned RANGE_W  = 3;
  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic {
    PXO_PH_FIRST,
    PXO_PH_SECOND
  } pxo_phase_type;

endpackage

// [test/pxo_downstream_model.sv]
`timescale 1ns/1ns
`default_nettype none

module pxo_downstream_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic hold,
  input  wire logic slow,
  output var  logic out_ready
);
  logic [7:0] lfsr;

  // slow mode stalls on a pseudo-random pattern
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr      <= 8'h5A;
      out_ready <= 1'b0;
    end else begin
      lfsr      <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      out_ready <= !hold && (!slow || lfsr[0]);
    end
  end
endmodule

`default_nettype wire

// [test/pxo_output_port_asserts.sv]
`timescale 1ns/1ns
`default_nettype none

module pxo_output_port_asserts #(
  parameter int unsigned CHAN_W   = pxo_pkg::CHAN_W,
  parameter int unsigned GAIN_W   = 8,
  parameter int unsigned OFFSET_W = 8
) (
  input wire logic                core_clk,
  input wire logic                reset_n,
  input wire logic                reg_wr_en,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wr_data,
  input wire logic [2:0]          range_flag_in,
  input wire logic                input_set_select,
  input wire logic [GAIN_W-1:0]   gain_monitor_pin,
  input wire logic [3*CHAN_W-1:0] port_a_data,
  input wire logic                port_a_strobe,
  input wire logic                port_a_oe,
  input wire logic                port_b_strobe,
  input wire logic                port_b_oe,
  input wire logic [2:0]          range_flag_out,
  input wire logic                range_flag_oe
);
  logic [7:0] fmt_sh;
  logic [4:0] tri_sh;
  logic [3:0] quiet;
  wire logic wr_fmt = reg_wr_en && reg_addr == pxo_pkg::PIXEL_FORMAT_CONTROL_ADDR;
  wire logic wr_tri = reg_wr_en && reg_addr == pxo_pkg::PORT_TRISTATE_CONTROL_ADDR;
  wire logic settled = quiet >= 4'h4;

  // mirrors of the write-only registers, and cycles since the last write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt_sh <= pxo_pkg::FMT_RESET;
      tri_sh <= pxo_pkg::TRI_RESET;
      quiet  <= 4'h0;
    end else begin
      fmt_sh <= wr_fmt ? reg_wr_data : fmt_sh;
      tri_sh <= wr_tri ? reg_wr_data[4:0] : tri_sh;
      quiet  <= reg_wr_en ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_float_b_oe: assert property (wr_tri ##1 !reg_wr_en |-> ##1 port_b_oe == !$past(reg_wr_data[4], 2))
    else $error("port b drive enable does not follow its float bit");
  a_float_a_oe: assert property (wr_tri ##1 !reg_wr_en |-> ##1 port_a_oe == !$past(reg_wr_data[3], 2))
    else $error("port a drive enable does not follow its float bit");
  a_range_oe: assert property (wr_tri ##1 !reg_wr_en |-> ##1 range_flag_oe == !$past(reg_wr_data[2], 2))
    else $error("range flag drive enable does not follow its float bit");
  a_input_set: assert property (wr_fmt ##1 !reg_wr_en |-> ##1 input_set_select == $past(reg_wr_data[7], 2))
    else $error("input set select does not follow the format register");
  a_gain_unused: assert property (wr_fmt && reg_wr_data[5:4] == 2'h3 ##1 !reg_wr_en |-> ##1 gain_monitor_pin == '0)
    else $error("gain monitor not zero for the unused code");
  a_range_pass: assert property ($past(reset_n) && !$past(tri_sh[1]) |-> range_flag_out == $past(range_flag_in))
    else $error("range flags not passed through in normal mode");
  a_test_level: assert property ($past(tri_sh[1]) && $stable(tri_sh) |-> port_a_data == {(3*CHAN_W){tri_sh[0]}} && range_flag_out == {3{tri_sh[0]}} && !port_a_strobe)
    else $error("test mode level not forced on the outputs");
  a_sync_pair: assert property (settled && fmt_sh[2] && !fmt_sh[0] && !tri_sh[1] |-> port_a_strobe == port_b_strobe)
    else $error("synchronous ports updated on different edges");
  a_stagger_lag: assert property (settled && fmt_sh[2] && fmt_sh[0] && !tri_sh[1] && port_a_strobe |-> !port_b_strobe ##1 port_b_strobe)
    else $error("interleaved port b does not lag port a by one clock");
  a_single_port: assert property (settled && !fmt_sh[2] |-> !port_b_strobe)
    else $error("port b updated in single port mode");
  a_reset_float: assert property ($rose(reset_n) |-> !port_a_oe && !port_b_oe && !range_flag_oe && !input_set_select)
    else $error("outputs not floating after reset");
endmodule

bind pxo_output_port pxo_output_port_asserts #(.CHAN_W(CHAN_W), .GAIN_W(GAIN_W), .OFFSET_W(OFFSET_W)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .range_flag_in(range_flag_in), .input_set_select(input_set_select),
  .gain_monitor_pin(gain_monitor_pin), .port_a_data(port_a_data), .port_a_strobe(port_a_strobe),
  .port_a_oe(port_a_oe), .port_b_strobe(port_b_strobe), .port_b_oe(port_b_oe),
  .range_flag_out(range_flag_out), .range_flag_oe(range_flag_oe));

`default_nettype wire

// [test/pxo_output_port_test.sv]
`timescale 1ns/1ns
`default_nettype none

module pxo_output_port_test;
  logic              core_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              reg_wr_en = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wr_data = 8'h00;
  logic              adc_valid = 1'b0;
  logic [23:0]       set1 = 24'h000000;
  logic [23:0]       set2 = 24'h000000;
  logic              blank = 1'b0;
  logic signed [7:0] r_off = 8'h00;
  logic signed [7:0] g_off = 8'h00;
  logic signed [7:0] b_off = 8'h00;
  logic [7:0]        r_gain = 8'h00;
  logic [7:0]        g_gain = 8'h00;
  logic [7:0]        b_gain = 8'h00;
  logic [2:0]        rf_in = 3'h0;
  logic              hold = 1'b0;
  logic              slow = 1'b0;
  logic              test_mode = 1'b0;
  logic [7:0]        fmt = 8'h00;
  logic [23:0]       b_exp = 24'h000000;
  logic [23:0]       expq[$];
  integer            seed = 32'h31CF;
  int                n_mismatch = 0;
  int                checked = 0;
  wire logic         out_ready, adc_ready, in_sel, th_dis;
  wire logic         a_stb, a_oe, b_stb, b_oe, rf_oe;
  wire logic [7:0]   gain_pin;
  wire logic [23:0]  a_data, b_data;
  wire logic [2:0]   rf_out;

  always #5 core_clk = ~core_clk;

  pxo_output_port DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .adc_set1_pixel(set1), .adc_set2_pixel(set2), .blank_active(blank),
    .red_offset_value(r_off), .green_offset_value(g_off), .blue_offset_value(b_off),
    .red_gain_level(r_gain), .green_gain_level(g_gain), .blue_gain_level(b_gain),
    .range_flag_in(rf_in), .out_ready(out_ready), .input_set_select(in_sel),
    .track_hold_disable(th_dis), .gain_monitor_pin(gain_pin), .port_a_data(a_data),
    .port_a_strobe(a_stb), .port_a_oe(a_oe), .port_b_data(b_data), .port_b_strobe(b_stb),
    .port_b_oe(b_oe), .range_flag_out(rf_out), .range_flag_oe(rf_oe));
  pxo_downstream_model u_far (.core_clk(core_clk), .reset_n(reset_n), .hold(hold), .slow(slow),
    .out_ready(out_ready));

  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp_pix(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_pix({23'h0, got}, {23'h0, exp});
  endtask

  function automatic logic [7:0] clampv(input logic signed [7:0] v);
    return v[7] ? 8'h00 : v;
  endfunction

  function automatic logic [23:0] expect_pix();
    if (blank && !fmt[3]) return {clampv(r_off), clampv(g_off), clampv(b_off)};
    return fmt[7] ? set2 : set1;
  endfunction

  function automatic logic [7:0] expect_gain(input logic [1:0] code);
    return code == 2'h0 ? r_gain : code == 2'h1 ? g_gain : code == 2'h2 ? b_gain : 8'h00;
  endfunction

  function automatic logic [23:0] pop();
    if (expq.size() == 0) return 24'hXXXXXX;
    return expq.pop_front();
  endfunction

  // pairs are formed in arrival order, even pixel first
  always @(negedge core_clk) begin : mon
    logic [23:0] ev;
    logic [23:0] od;
    if (a_stb === 1'b1) begin
      ev = pop();
      od = fmt[2] ? pop() : ev;
      cmp_pix(a_data, fmt[1] && fmt[2] ? od : ev);
      b_exp = fmt[1] ? ev : od;
    end
    if (b_stb === 1'b1) begin
      cmp_pix(b_data, b_exp);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    fmt = a == pxo_pkg::PIXEL_FORMAT_CONTROL_ADDR ? d : fmt;
    @(posedge core_clk);
    #1;
  endtask

  task automatic send();
    int i;
    logic rdy;
    adc_valid = 1'b1;
    set1 = 24'($random(seed));
    set2 = 24'($random(seed));
    blank = ($random(seed) & 3) == 0;
    rf_in = 3'($random(seed));
    for (i = 0; i < 50; i++) begin
      rdy = adc_ready;
      @(posedge core_clk);
      #1;
      if (rdy === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      give_verdict();
    end else if (!test_mode) begin
      expq.push_back(expect_pix());
    end
  endtask

  task automatic phase(input logic [7:0] f, input int n);
    r_off = 8'($random(seed));
    g_off = 8'($random(seed));
    b_off = 8'($random(seed));
    r_gain = 8'($random(seed));
    g_gain = 8'($random(seed));
    b_gain = 8'($random(seed));
    wr(pxo_pkg::PIXEL_FORMAT_CONTROL_ADDR, f);
    repeat (2) @(posedge core_clk);
    #1;
    cmp_pix({16'h0000, gain_pin}, {16'h0000, expect_gain(f[5:4])});
    cmp_bit(in_sel, f[7]);
    cmp_bit(th_dis, f[6]);
    repeat (n) send();
    adc_valid = 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
    cmp_pix(24'(expq.size()), 24'h000000);
    expq.delete();
  endtask

  initial begin
    int k;
    r_gain = 8'($random(seed));
    repeat (12) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    @(posedge core_clk);
    #1;
    cmp_bit(a_oe | b_oe | rf_oe, 1'b0);
    cmp_pix({16'h0000, gain_pin}, {16'h0000, r_gain});
    wr(8'h19, 8'h00);
    @(posedge core_clk);
    #1;
    cmp_bit(a_oe | b_oe | rf_oe, 1'b0);
    for (k = 2; k < 5; k++) begin
      wr(pxo_pkg::PORT_TRISTATE_CONTROL_ADDR, 8'hE0 | 8'(1 << k));
      @(posedge core_clk);
      #1;
      cmp_bit(b_oe, k != 4);
      cmp_bit(a_oe, k != 3);
      cmp_bit(rf_oe, k != 2);
    end
    wr(pxo_pkg::PORT_TRISTATE_CONTROL_ADDR, 8'h00);
    phase(8'h34, 2);
    slow = 1'b1;
    for (k = 0; k < 16; k++) begin
      phase((8'($random(seed)) & 8'hB8) | 8'(k % 8), 8);
    end
    slow = 1'b0;
    wr(pxo_pkg::PIXEL_FORMAT_CONTROL_ADDR, 8'h00);
    hold = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    send();
    send();
    cmp_bit(adc_ready, 1'b0);
    adc_valid = 1'b0;
    hold = 1'b0;
    phase(8'h00, 2);
    test_mode = 1'b1;
    wr(pxo_pkg::PORT_TRISTATE_CONTROL_ADDR, 8'h02);
    phase(8'h04, 4);
    cmp_pix(b_data, 24'h000000);
    wr(pxo_pkg::PORT_TRISTATE_CONTROL_ADDR, 8'h03);
    phase(8'h00, 4);
    cmp_pix(a_data, 24'hFFFFFF);
    cmp_pix(b_data, 24'hFFFFFF);
    give_verdict();
  end
endmodule

`default_nettype wire
